// [sdi_rx_proc_pkg.sv]
// Package of constants and carrier types for the output processing control
package sdi_rx_proc_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [11:0] OUT_PROC_CTRL_ONE_ADDR = 12'h0000;
   localparam logic [11:0] OUT_PROC_CTRL_TWO_ADDR = 12'h0001;

   // Reset values
   localparam logic [15:0] OUT_PROC_CTRL_ONE_RST = 16'h0000;
   localparam logic [15:0] OUT_PROC_CTRL_TWO_RST = 16'h0100;

   // Writable bits; bit 15 of the first register is read-only zero
   localparam logic [15:0] OUT_PROC_CTRL_ONE_WMASK = 16'h7fff;
   localparam logic [15:0] OUT_PROC_CTRL_TWO_WMASK = 16'hffff;

   // ************************************************************
   // Field positions, first register
   // ************************************************************
   localparam int TIMING_REF_INSERT_OFF_S1_BIT = 0;
   localparam int LINE_NO_INSERT_OFF_S1_BIT = 1;
   localparam int CRC_INSERT_OFF_S1_BIT = 2;
   localparam int ANC_SUM_INSERT_OFF_S1_BIT = 3;

   // ************************************************************
   // Field positions, second register
   // ************************************************************
   localparam int TIMING_REF_INSERT_OFF_S2_BIT = 0;
   localparam int LINE_NO_INSERT_OFF_S2_BIT = 1;
   localparam int CRC_INSERT_OFF_S2_BIT = 2;
   localparam int ANC_SUM_INSERT_OFF_S2_BIT = 3;
   localparam int BAD_WORD_REMAP_OFF_S2_BIT = 4;
   localparam int ANC_EXTRACT_STREAM_SELECT_BIT = 7;
   localparam int LEVEL_CONVERSION_OFF_BIT = 8;
   localparam int STREAM_SWAP_BIT = 9;
   localparam int PAYLOAD_ID_REGEN_OFF_BIT = 10;
   localparam int TIMING_REF_REMAP_OFF_S2_BIT = 12;
   localparam int ASI_POLARITY_AUTODETECT_OFF_BIT = 13;
   localparam int ASI_POLARITY_FORCE_BIT = 14;

   // ************************************************************
   // Carrier types
   // ************************************************************
   typedef struct packed {
      logic wr;
      logic rd;
      logic [11:0] addr;
      logic [15:0] wdata;
   } host_req_s;

   typedef struct packed {
      logic asi_mode;
      logic mode_3g;
      logic level_b;
      logic out_20bit;
   } rx_mode_s;

   typedef struct packed {
      logic [9:0] stream_one;
      logic [9:0] stream_two;
   } stream_pair_s;

   typedef struct packed {
      logic timing_ref_insert_s1;
      logic line_no_insert_s1;
      logic crc_insert_s1;
      logic anc_sum_insert_s1;
      logic timing_ref_insert_s2;
      logic line_no_insert_s2;
      logic crc_insert_s2;
      logic anc_sum_insert_s2;
      logic bad_word_remap_s2;
      logic timing_ref_remap_s2;
      logic payload_id_regen;
      logic level_conversion;
      logic asi_invert_decode;
   } proc_enable_s;

   // Output word phase in 10-bit double data rate mode
   typedef enum logic [1:0] {
      PH_FIRST = 2'b01,
      PH_SECOND = 2'b10
   } ddr_phase_e;

endpackage

// [sdi_rx_output_proc_control.sv]
// Output processing control registers and stream routing of the receiver
// Notes on behaviour
// R1: Stream one checksum mask bit 3 stops ancillary checksum insertion.
// R2: Stream one CRC mask bit 2 stops HD/3G CRC word insertion.
// R3: Stream one line number mask bit 1 stops line number insertion.
// R4: Stream one timing reference mask bit 0 stops TRS insertion.
// R5: ASI, autodetect off: bit 14 high non-inverted, low inverted decoding.
// R6: ASI bit 13 high disables inversion autodetect; low ignores bit 14.
// R7: Bit 12 disables stream two TRS word remap, Level B only.
// R8: Bit 10 disables payload ID packet regeneration for Level B.
// R9: Host should clear bit 10 only while level conversion is enabled.
// R10: 3G 20-bit: stream one on [19:10], two on [9:0]; swap exchanges.
// R11: 10-bit DDR: stream two word first by default; swap puts one first.
// R12: Bit 8 disables Level B to A conversion, 3G Level B only, resets 1.
// R13: Bit 7 picks the stream feeding ancillary extraction in Level B.
// R14: Bit 4 disables stream two illegal word remap, Level B only.
// R15: Bit 3 stops stream two ancillary checksum insertion, Level B only.
// R16: Bit 2 stops stream two CRC insertion, Level B only.
// R17: Bit 1 stops stream two line number insertion, Level B only.
// R18: Bit 0 stops stream two TRS insertion, Level B only.
// R19: All insertion and remap masks reset to zero, features active.
`timescale 1ns/10ps
module sdi_rx_output_proc_control (
   input wire logic ref_clk,
   input wire logic rst,
   input wire sdi_rx_proc_pkg::host_req_s host_req,
   output logic [15:0] host_rdata,
   output logic host_rvalid,
   input wire sdi_rx_proc_pkg::rx_mode_s rx_mode,
   input wire logic asi_inversion_seen,
   input wire sdi_rx_proc_pkg::stream_pair_s stream_in,
   output sdi_rx_proc_pkg::proc_enable_s proc_enable,
   output logic [19:0] dout,
   output logic [9:0] anc_extract_word
);
   import sdi_rx_proc_pkg::*;

   // ************************************************************
   // State of the block
   // ************************************************************
   typedef struct packed {
      logic [15:0] ctrl_one;
      logic [15:0] ctrl_two;
      logic [15:0] rdata;
      logic rvalid;
      proc_enable_s enable;
      logic [19:0] dout;
      logic [9:0] anc_word;
      ddr_phase_e phase;
      logic [9:0] second_word;
   } state_s;

   state_s state_reg;
   state_s state_next;

   // ************************************************************
   // Decoding helpers
   // ************************************************************

   // Register read data for an address, unmapped reads as zero
   function automatic logic [15:0] read_word(
      input logic [11:0] addr,
      input logic [15:0] one,
      input logic [15:0] two
   );
      logic [15:0] word;
      word = 16'h0000;
      unique case (addr)
         OUT_PROC_CTRL_ONE_ADDR: begin
            word = one & OUT_PROC_CTRL_ONE_WMASK;
         end
         OUT_PROC_CTRL_TWO_ADDR: begin
            word = two;
         end
         default: begin
            word = 16'h0000;
         end
      endcase
      return word;
   endfunction

   // Feature enable from a mask bit and a qualifying mode
   function automatic logic feature_on(
      input logic mode_ok,
      input logic mask
   );
      return mode_ok & ~mask;
   endfunction

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      logic [15:0] one;
      logic [15:0] two;
      logic level_b_3g;
      logic swap;
      one = state_reg.ctrl_one;
      two = state_reg.ctrl_two;
      level_b_3g = rx_mode.mode_3g & rx_mode.level_b;
      swap = state_reg.ctrl_two[STREAM_SWAP_BIT];
      state_next = state_reg;

      // Host writes, only writable bits change
      if (host_req.wr) begin
         if (host_req.addr == OUT_PROC_CTRL_ONE_ADDR) begin
            one = host_req.wdata & OUT_PROC_CTRL_ONE_WMASK;
         end
         if (host_req.addr == OUT_PROC_CTRL_TWO_ADDR) begin
            two = host_req.wdata & OUT_PROC_CTRL_TWO_WMASK; // [R9]
         end
      end
      state_next.ctrl_one = one;
      state_next.ctrl_two = two;

      // Host reads answer one cycle later
      state_next.rvalid = host_req.rd;
      if (host_req.rd) begin
         state_next.rdata = read_word(host_req.addr, state_reg.ctrl_one,
                                      state_reg.ctrl_two);
      end

      // Stream one insertion controls, all input formats
      state_next.enable.anc_sum_insert_s1 =
         feature_on(1'b1, state_reg.ctrl_one[ANC_SUM_INSERT_OFF_S1_BIT]); // [R1]
      state_next.enable.crc_insert_s1 =
         feature_on(1'b1, state_reg.ctrl_one[CRC_INSERT_OFF_S1_BIT]); // [R2]
      state_next.enable.line_no_insert_s1 =
         feature_on(1'b1, state_reg.ctrl_one[LINE_NO_INSERT_OFF_S1_BIT]); // [R3]
      state_next.enable.timing_ref_insert_s1 =
         feature_on(1'b1,
                    state_reg.ctrl_one[TIMING_REF_INSERT_OFF_S1_BIT]); // [R4]

      // Stream two controls, 3G Level B only
      state_next.enable.timing_ref_remap_s2 =
         feature_on(level_b_3g,
                    state_reg.ctrl_two[TIMING_REF_REMAP_OFF_S2_BIT]); // [R7]
      state_next.enable.bad_word_remap_s2 =
         feature_on(level_b_3g,
                    state_reg.ctrl_two[BAD_WORD_REMAP_OFF_S2_BIT]); // [R14]
      state_next.enable.anc_sum_insert_s2 =
         feature_on(level_b_3g,
                    state_reg.ctrl_two[ANC_SUM_INSERT_OFF_S2_BIT]); // [R15]
      state_next.enable.crc_insert_s2 =
         feature_on(level_b_3g,
                    state_reg.ctrl_two[CRC_INSERT_OFF_S2_BIT]); // [R16]
      state_next.enable.line_no_insert_s2 =
         feature_on(level_b_3g,
                    state_reg.ctrl_two[LINE_NO_INSERT_OFF_S2_BIT]); // [R17]
      state_next.enable.timing_ref_insert_s2 =
         feature_on(level_b_3g,
                    state_reg.ctrl_two[TIMING_REF_INSERT_OFF_S2_BIT]); // [R18]

      // Payload ID regeneration and level conversion
      state_next.enable.payload_id_regen =
         feature_on(level_b_3g,
                    state_reg.ctrl_two[PAYLOAD_ID_REGEN_OFF_BIT]); // [R8]
      state_next.enable.level_conversion =
         feature_on(level_b_3g,
                    state_reg.ctrl_two[LEVEL_CONVERSION_OFF_BIT]); // [R12]

      // ASI polarity: zero outside ASI, forced when autodetect off, else detected
      if (!rx_mode.asi_mode) begin
         state_next.enable.asi_invert_decode = 1'b0;
      end else if (state_reg.ctrl_two[ASI_POLARITY_AUTODETECT_OFF_BIT]) begin
         state_next.enable.asi_invert_decode =
            ~state_reg.ctrl_two[ASI_POLARITY_FORCE_BIT]; // [R5]
      end else begin
         state_next.enable.asi_invert_decode = asi_inversion_seen; // [R6]
      end

      // Ancillary extraction source, stream two when bit set in Level B
      if (level_b_3g && state_reg.ctrl_two[ANC_EXTRACT_STREAM_SELECT_BIT]) begin
         state_next.anc_word = stream_in.stream_two; // [R13]
      end else begin
         state_next.anc_word = stream_in.stream_one; // [R13]
      end

      // Parallel output routing
      if (!rx_mode.mode_3g) begin
         state_next.phase = PH_FIRST;
         state_next.second_word = 10'h000;
         state_next.dout = {stream_in.stream_one, stream_in.stream_two};
      end else if (rx_mode.out_20bit) begin
         state_next.phase = PH_FIRST;
         state_next.second_word = 10'h000;
         if (swap) begin
            state_next.dout = {stream_in.stream_two,
                               stream_in.stream_one}; // [R10]
         end else begin
            state_next.dout = {stream_in.stream_one,
                               stream_in.stream_two}; // [R10]
         end
      end else begin
         // 10-bit DDR: pair captured in first phase, second word held
         unique case (state_reg.phase)
            PH_FIRST: begin
               state_next.phase = PH_SECOND;
               if (swap) begin
                  state_next.dout = {10'h000, stream_in.stream_one}; // [R11]
                  state_next.second_word = stream_in.stream_two;
               end else begin
                  state_next.dout = {10'h000, stream_in.stream_two}; // [R11]
                  state_next.second_word = stream_in.stream_one;
               end
            end
            PH_SECOND: begin
               state_next.phase = PH_FIRST;
               state_next.dout = {10'h000, state_reg.second_word}; // [R11]
            end
            default: begin
               state_next.phase = PH_FIRST;
               state_next.dout = 20'h0_0000;
            end
         endcase
      end
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_reg.ctrl_one <= OUT_PROC_CTRL_ONE_RST; // [R19]
         state_reg.ctrl_two <= OUT_PROC_CTRL_TWO_RST; // [R12] [R19]
         state_reg.rdata <= 16'h0000;
         state_reg.rvalid <= 1'b0;
         state_reg.enable <= '0;
         state_reg.dout <= 20'h0_0000;
         state_reg.anc_word <= 10'h000;
         state_reg.phase <= PH_FIRST;
         state_reg.second_word <= 10'h000;
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from flip-flops
   assign host_rdata = state_reg.rdata;
   assign host_rvalid = state_reg.rvalid;
   assign proc_enable = state_reg.enable;
   assign dout = state_reg.dout;
   assign anc_extract_word = state_reg.anc_word;

endmodule

// [sdi_host_model.sv]
// Host controller model issuing register writes and reads
`timescale 1ns/10ps
module sdi_host_model (
   input wire logic ref_clk,
   output sdi_rx_proc_pkg::host_req_s host_req,
   input wire logic [15:0] host_rdata,
   input wire logic host_rvalid
);
   import sdi_rx_proc_pkg::*;
   initial host_req = '0;
   // One strobe per call; a released bus shows the inverse, never old data
   task automatic put(input logic w, input logic [11:0] a,
      input logic [15:0] d);
      @(negedge ref_clk);
      host_req = {w, ~w, a, d};
      @(negedge ref_clk);
      host_req = {2'b00, ~a, ~d};
   endtask
   task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
      put(1'b1, a, d);
   endtask
   // Answer stands half a cycle after the taking edge
   task automatic rd_reg(input logic [11:0] a, output logic [15:0] d);
      put(1'b0, a, 16'h0000);
      d = (host_rvalid === 1'b1) ? host_rdata : 'x;
   endtask
endmodule

// [sdi_rx_output_proc_control_assertions.sv]
// Port checker for the output processing control block
`timescale 1ns/10ps
module sdi_proc_checker (
   input wire logic ref_clk,
   input wire logic rst,
   input wire sdi_rx_proc_pkg::host_req_s host_req,
   input wire logic [15:0] host_rdata,
   input wire logic host_rvalid,
   input wire sdi_rx_proc_pkg::rx_mode_s rx_mode,
   input wire logic asi_inversion_seen,
   input wire sdi_rx_proc_pkg::stream_pair_s stream_in,
   input wire sdi_rx_proc_pkg::proc_enable_s proc_enable,
   input wire logic [19:0] dout,
   input wire logic [9:0] anc_extract_word
);
   import sdi_rx_proc_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic lb;
   logic [3:0] wrev;
   // Level B flag and mask bits in enable order
   assign lb = rx_mode.mode_3g & rx_mode.level_b;
   assign wrev = {host_req.wdata[0], host_req.wdata[1], host_req.wdata[2],
      host_req.wdata[3]};
   s1_mask_a: assert property (
      host_req.wr && host_req.addr == 12'h000 |=> ##1
      proc_enable[12:9] == ~$past(wrev, 2)) else $error("s1 enables wrong");
   s2_mask_a: assert property (
      host_req.wr && host_req.addr == 12'h001 ##1 lb |=>
      proc_enable[8:5] == ~$past(wrev, 2)) else $error("s2 enables wrong");
   lb_only_a: assert property (!lb |=> proc_enable[8:1] == 8'h00)
      else $error("level b feature on outside level b");
   asi_off_a: assert property (
      !rx_mode.asi_mode |=> !proc_enable.asi_invert_decode)
      else $error("asi decode set outside asi");
   asi_auto_a: assert property (
      host_req.wr && host_req.addr == 12'h001 && !host_req.wdata[13] ##1
      rx_mode.asi_mode |=> proc_enable.asi_invert_decode ==
      $past(asi_inversion_seen)) else $error("autodetect not followed");
   plain_order_a: assert property (!rx_mode.mode_3g |=>
      dout == $past(stream_in)) else $error("non 3g order wrong");
   swap_pair_a: assert property (
      rx_mode.mode_3g && rx_mode.out_20bit |=> dout == $past(stream_in) ||
      dout == {$past(stream_in.stream_two), $past(stream_in.stream_one)})
      else $error("20 bit streams wrong");
   ddr_upper_a: assert property (
      rx_mode.mode_3g && !rx_mode.out_20bit |=> dout[19:10] == 10'h000)
      else $error("ddr upper bits set");
   anc_default_a: assert property (!lb |=>
      anc_extract_word == $past(stream_in.stream_one))
      else $error("anc stream wrong");
   rd_c: cover property (host_req.rd ##1 host_rvalid);
   ddr_c: cover property (rx_mode.mode_3g && !rx_mode.out_20bit);
   asi_c: cover property (proc_enable.asi_invert_decode);
endmodule
bind sdi_rx_output_proc_control sdi_proc_checker u_chk (.ref_clk, .rst,
   .host_req, .host_rdata, .host_rvalid, .rx_mode, .asi_inversion_seen,
   .stream_in, .proc_enable, .dout, .anc_extract_word);

// [tb_sdi_rx_output_proc_control.sv]
// Self-checking bench for the output processing control block
`timescale 1ns/10ps
module tb_sdi_rx_output_proc_control;
   import sdi_rx_proc_pkg::*;
   `define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
      err_count++; end end
   logic ref_clk = 0;
   logic rst = 1;
   logic seen = 0;
   rx_mode_s mode = '0;
   stream_pair_s sin = '0;
   host_req_s host_req;
   logic [15:0] host_rdata, rd, r1, r2;
   logic host_rvalid;
   proc_enable_s pe;
   logic [19:0] dout;
   logic [9:0] anc;
   logic [29:0] exp30;
   int err_count = 0;
   int n_tests = 0;
   int cycles = 0;
   integer seed = 32'h4132_25fc;
   always #5 ref_clk = ~ref_clk;
   sdi_rx_output_proc_control u_dut (.ref_clk(ref_clk), .rst(rst),
      .host_req(host_req), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
      .rx_mode(mode), .asi_inversion_seen(seen), .stream_in(sin),
      .proc_enable(pe), .dout(dout), .anc_extract_word(anc));
   sdi_host_model u_host (.ref_clk(ref_clk), .host_req(host_req),
      .host_rdata(host_rdata), .host_rvalid(host_rvalid));
   // Expected enables and routing for current inputs
   function automatic logic [12:0] exp_en(logic [15:0] a, logic [15:0] b);
      logic [7:0] lb;
      lb = {8{mode.mode_3g & mode.level_b}};
      return {~a[0], ~a[1], ~a[2], ~a[3], lb & ~{b[0], b[1], b[2], b[3],
         b[4], b[12], b[10], b[8]}, mode.asi_mode & (b[13] ? ~b[14] : seen)};
   endfunction
   function automatic logic [29:0] exp_out(logic [15:0] b);
      logic lb;
      lb = mode.mode_3g & mode.level_b;
      return {(mode.mode_3g & b[9]) ? {sin.stream_two, sin.stream_one} : sin,
         (lb & b[7]) ? sin.stream_two : sin.stream_one};
   endfunction
   task automatic give_verdict;
      if (err_count == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Hang guard
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         give_verdict;
      end
   end
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      repeat (4) @(negedge ref_clk);
      rst = 0;
      u_host.rd_reg(12'h000, rd);
      `CHK(rd, 16'h0000)
      u_host.rd_reg(12'h001, rd);
      `CHK(rd, 16'h0100)
      `CHK(13'(pe), exp_en(16'h0000, 16'h0100))
      u_host.wr_reg(12'h002, 16'hffff);
      u_host.rd_reg(12'h002, rd);
      `CHK(rd, 16'h0000)
      u_host.rd_reg(12'h000, rd);
      `CHK(rd, 16'h0000)
      for (int i = 0; i < 80; i++) begin
         mode = rx_mode_s'($random(seed));
         seen = $random(seed);
         r1 = $random(seed);
         r2 = $random(seed);
         if (!r2[10]) r2[8] = 1'b0;
         u_host.wr_reg(12'h000, r1);
         u_host.wr_reg(12'h001, r2);
         u_host.rd_reg(12'h000, rd);
         `CHK(rd, r1 & 16'h7fff)
         u_host.rd_reg(12'h001, rd);
         `CHK(rd, r2)
         `CHK(13'(pe), exp_en(r1, r2))
         if (mode.out_20bit || !mode.mode_3g) begin
            sin = stream_pair_s'($random(seed));
            exp30 = exp_out(r2);
            @(negedge ref_clk);
            `CHK({dout, anc}, exp30)
         end
      end
      // Double data rate word order, default and swapped
      for (int s = 0; s < 2; s++) begin
         u_host.wr_reg(12'h001, {6'h00, s[0], 9'h000});
         mode = 4'b0101;
         @(negedge ref_clk);
         mode = 4'b0100;
         sin = {10'h2a5, 10'h15a};
         @(negedge ref_clk);
         sin = ~sin;
         `CHK(dout, {10'h000, s ? 10'h2a5 : 10'h15a})
         @(negedge ref_clk);
         `CHK(dout, {10'h000, s ? 10'h15a : 10'h2a5})
      end
      give_verdict;
   end
endmodule
